// ==== ccu_defines.svh ====
/*
 * Register offsets, field positions, mode codes and reset values of the
 * capture/compare/PWM unit. Included by the package, the unit and the bench.
 */
`ifndef CCU_DEFINES_SVH
`define CCU_DEFINES_SVH

// Wishbone word offsets (byte addresses)
`define CCU_ADR_W        4
`define CCU_ADR_CTRL     4'h0
`define CCU_ADR_VLOW     4'h4
`define CCU_ADR_VHIGH    4'h8
`define CCU_ADR_FLAG     4'hc

// unit_control_reg fields
`define CCU_CTRL_W       6
`define CCU_CTRL_RST     6'h00
`define CCU_MODE_MSB     3
`define CCU_MODE_LSB     0
`define CCU_DLSB_MSB     5
`define CCU_DLSB_LSB     4

// Status register bits
`define CCU_FLAG_BIT     0
`define CCU_OUT_BIT      1

// mode_select_field codes
`define CCU_M_OFF        4'h0
`define CCU_M_CAP_FALL   4'h4
`define CCU_M_CAP_RISE   4'h5
`define CCU_M_CAP_4TH    4'h6
`define CCU_M_CAP_16TH   4'h7
`define CCU_M_CMP_SET    4'h8
`define CCU_M_CMP_CLR    4'h9
`define CCU_M_CMP_SWI    4'ha
`define CCU_M_CMP_SPEC   4'hb
`define CCU_M_PWM_TOP    2'h3
`define CCU_M_CAP_TOP    2'h1
`define CCU_M_CMP_TOP    2'h2

// Capture prescaler terminal counts
`define CCU_PS_W         4
`define CCU_PS_RST       4'h0
`define CCU_PS4_LAST     2'h3
`define CCU_PS16_LAST    4'hf

`define CCU_BYTE_RST     8'h00
`define CCU_DUTY_ZERO    10'h000
`define CCU_DUTY_STEP    10'h001

`endif

// ==== ccu_pkg.sv ====
/*
 * Types shared by the capture/compare/PWM unit.
 * Assumes ccu_defines.svh is on the include path.
 */
`include "ccu_defines.svh"

package ccu_pkg;

    typedef enum logic [1:0] {
        CCU_K_OFF,
        CCU_K_CAP,
        CCU_K_CMP,
        CCU_K_PWM
    } ccu_kind_t;

    // Mode field to unit kind; reserved codes 0001..0011 act as off
    function automatic ccu_kind_t ccu_kind(input logic [3:0] mode);
        case (mode[3:2])
            `CCU_M_PWM_TOP: ccu_kind = CCU_K_PWM;
            `CCU_M_CMP_TOP: ccu_kind = CCU_K_CMP;
            `CCU_M_CAP_TOP: ccu_kind = CCU_K_CAP;
            default:        ccu_kind = CCU_K_OFF;
        endcase
    endfunction : ccu_kind

endpackage : ccu_pkg

// ==== ccu_pin_sync.sv ====
/*
 * Three-stage synchroniser with agreement filter for the unit pin.
 * Assumes pin_i is asynchronous to clk_i.
 */
module ccu_pin_sync
    import ccu_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      level_o
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } ccu_sync_t;

    ccu_sync_t s_q;
    ccu_sync_t s_d;

    always_comb
    begin
        s_d    = s_q;
        s_d.s1 = pin_i;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        // First stage is never looked at here
        if (s_q.s2 == s_q.s3)
        begin
            s_d.lvl = s_q.s3;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign level_o = s_q.lvl;

endmodule : ccu_pin_sync

// ==== ccu_unit.sv ====
/*
 * Capture/compare/PWM unit with a classic Wishbone register slave.
 * Assumes external timer A (16 bit) and timer B (8 bit) logic on clk_i,
 * and a port block that owns the pin direction.
 */
// Design decisions made here: the placing of the registers and register access over Wishbone.
`include "ccu_defines.svh"

// What the document requires of this block and its software
// RULE1: Software keeps timer A synchronous when capturing.
// RULE2: Mode changes may fake a capture; software masks and clears the flag.
// RULE3: Four capture prescales; counter cleared when off or not capturing.
// RULE4: Switching between capture prescales keeps the counter; early capture possible.
// RULE5: Software writes zero to control before a new prescale.
// RULE6: Compare mode continuously checks value pair against timer A count.
// RULE7: On match drive pin high, low or keep, and set flag.
// RULE8: Writing zero to control forces the compare output latch low.
// RULE9: Software keeps timer A synchronous when comparing.
// RULE10: Software-interrupt compare leaves the pin and only sets the flag.
// RULE11: Special event match pulses timer A clear and conversion start.
// RULE12: Special event clear of timer A never sets its overflow flag.
// RULE13: PWM drives up to 10-bit duty; software makes pin an output.
// RULE14: Writing zero to control forces the PWM output latch low.
// RULE15: Period match: clear timer B, set pin unless duty zero, reload duty.
// RULE16: Timer B postscaler has no part in the PWM period.
// RULE17: Duty is value_low_reg bits above control bits 5:4.
// RULE18: Duty writes take effect after period match; value_high_reg read-only.
// RULE19: Duty double-buffered in value_high_reg plus a 2-bit latch.
// RULE20: Pin cleared when buffered duty equals timer B count with phase bits.
// RULE21: Duty above period never clears the pin; output stays high.
// RULE22: Software sets period, duty, direction, timer B, then PWM mode.
// RULE23: Mode 0000 off; 0100-0111 capture edges and prescales; 11xx PWM.
// RULE24: Modes 1000-1011 set, clear, interrupt, special event; all set flag.
// RULE25: Capture copies timer A into value pair and sets sticky flag.
// RULE26: PWM period is period plus one, times four clocks, times prescale.
// RULE27: PWM high time is duty times one quarter step times prescale.
module ccu_unit
    import ccu_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [15:0] timer_a_count_i,
    input  wire logic [7:0]  timer_b_count_i,
    input  wire logic [7:0]  timer_b_period_i,
    input  wire logic        timer_b_inc_i,
    input  wire logic [1:0]  timer_b_phase_i,
    input  wire logic        port_direction_i,
    input  wire logic        unit_pin_i,
    output logic             unit_pin_o,
    output logic             unit_pin_oe_o,
    output logic             unit_irq_flag_o,
    output logic             timer_a_clear_o,
    output logic             timer_a_ovf_block_o,
    output logic             conv_start_o,
    output logic             timer_b_clear_o
);

    typedef struct packed {
        logic [`CCU_CTRL_W-1:0] ctrl;
        logic [7:0]             vlow;
        logic [7:0]             vhigh;
        logic [1:0]             dlatch;
        logic [`CCU_PS_W-1:0]   ps;
        logic                   flag;
        logic                   out;
        logic                   pin;
        logic                   match;
        logic                   trig;
        logic                   ack;
        logic [7:0]             rdat;
    } ccu_state_t;

    ccu_state_t s_q;
    ccu_state_t s_d;

    ccu_kind_t   kind;
    logic [3:0]  mode;
    logic        pin_lvl;
    logic        pin_rise;
    logic        pin_fall;
    logic        req;
    logic        wr;
    logic        zero_wr;
    logic        flag_clr;
    logic        cap_ev;
    logic        cmp_match;
    logic        cmp_hit;
    logic        per_hit;
    logic        duty_hit;
    logic [9:0]  duty_new;
    logic [9:0]  duty_buf;
    logic [9:0]  duty_next;
    logic [7:0]  rd_byte;

    ccu_pin_sync u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (unit_pin_i),
        .level_o (pin_lvl)
    );

    assign mode     = s_q.ctrl[`CCU_MODE_MSB:`CCU_MODE_LSB];
    assign kind     = ccu_kind(mode); // RULE23
    assign pin_rise = pin_lvl & ~s_q.pin;
    assign pin_fall = ~pin_lvl & s_q.pin;

    // Bus decode: one request per ack, write lands with the ack
    assign req      = wb_cyc_i & wb_stb_i & ~s_q.ack;
    assign wr       = req & wb_we_i & wb_sel_i[0];
    assign zero_wr  = wr && (wb_adr_i == `CCU_ADR_CTRL)
                      && (wb_dat_i[`CCU_CTRL_W-1:0] == `CCU_CTRL_RST);
    assign flag_clr = wr && (wb_adr_i == `CCU_ADR_FLAG) && wb_dat_i[`CCU_FLAG_BIT];

    // Prescaler counts wrap, so a 4th-edge switch from 16th may fire early
    assign cap_ev = (kind == CCU_K_CAP) && (
                    (mode == `CCU_M_CAP_FALL && pin_fall) ||
                    (mode == `CCU_M_CAP_RISE && pin_rise) ||
                    (mode == `CCU_M_CAP_4TH && pin_rise
                        && s_q.ps[1:0] == `CCU_PS4_LAST) ||
                    (mode == `CCU_M_CAP_16TH && pin_rise
                        && s_q.ps == `CCU_PS16_LAST)); // RULE4

    assign cmp_match = ({s_q.vhigh, s_q.vlow} == timer_a_count_i); // RULE6
    // Act once per match so a stalled timer does not retrigger
    assign cmp_hit   = (kind == CCU_K_CMP) && cmp_match && ~s_q.match;

    assign duty_new = {s_q.vlow, s_q.ctrl[`CCU_DLSB_MSB:`CCU_DLSB_LSB]}; // RULE17
    assign duty_buf = {s_q.vhigh, s_q.dlatch}; // RULE19
    // Postscaler never enters; only count, period and the increment strobe do
    assign per_hit  = (kind == CCU_K_PWM) && timer_b_inc_i
                      && (timer_b_count_i == timer_b_period_i); // RULE16
    // One step ahead: the latch is a flop, so it falls on the matching step
    assign duty_next = 10'({timer_b_count_i, timer_b_phase_i} + `CCU_DUTY_STEP);
    // Duty above period never matches, so the pin stays high
    assign duty_hit  = (kind == CCU_K_PWM)
                       && (duty_next == duty_buf); // RULE20 RULE21 RULE27

    always_comb
    begin
        rd_byte = `CCU_BYTE_RST;
        case (wb_adr_i)
            `CCU_ADR_CTRL:
            begin
                rd_byte[`CCU_CTRL_W-1:0] = s_q.ctrl;
            end
            `CCU_ADR_VLOW:  rd_byte = s_q.vlow;
            `CCU_ADR_VHIGH: rd_byte = s_q.vhigh;
            `CCU_ADR_FLAG:
            begin
                rd_byte[`CCU_FLAG_BIT] = s_q.flag;
                rd_byte[`CCU_OUT_BIT]  = s_q.out;
            end
            default: rd_byte = `CCU_BYTE_RST;
        endcase
    end

    always_comb
    begin
        s_d       = s_q;
        s_d.ack   = req;
        s_d.trig  = 1'b0;
        s_d.pin   = pin_lvl;
        s_d.match = cmp_match && (kind == CCU_K_CMP);
        if (req)
        begin
            s_d.rdat = rd_byte;
        end

        // Software side first, so hardware events below win, except the zero control write applied last
        if (wr)
        begin
            case (wb_adr_i)
                `CCU_ADR_CTRL: s_d.ctrl = wb_dat_i[`CCU_CTRL_W-1:0];
                `CCU_ADR_VLOW: s_d.vlow = wb_dat_i[7:0];
                `CCU_ADR_VHIGH:
                begin
                    if (kind != CCU_K_PWM)
                    begin
                        s_d.vhigh = wb_dat_i[7:0]; // RULE18
                    end
                end
                default:
                begin
                end
            endcase
        end
        if (flag_clr)
        begin
            s_d.flag = 1'b0;
        end

        // Capture prescaler
        if (kind != CCU_K_CAP)
        begin
            s_d.ps = `CCU_PS_RST; // RULE3
        end
        else if (pin_rise && (mode == `CCU_M_CAP_4TH || mode == `CCU_M_CAP_16TH))
        begin
            s_d.ps = `CCU_PS_W'(s_q.ps + 1'b1);
        end

        if (cap_ev)
        begin
            s_d.vlow  = timer_a_count_i[7:0]; // RULE25
            s_d.vhigh = timer_a_count_i[15:8];
            s_d.flag  = 1'b1;
        end

        if (cmp_hit)
        begin
            s_d.flag = 1'b1; // RULE24
            case (mode)
                `CCU_M_CMP_SET:  s_d.out  = 1'b1; // RULE7
                `CCU_M_CMP_CLR:  s_d.out  = 1'b0;
                `CCU_M_CMP_SPEC: s_d.trig = 1'b1; // RULE11
                default:
                begin
                    // Software-interrupt compare: pin left alone
                    s_d.out = s_q.out; // RULE10
                end
            endcase
        end

        if (per_hit)
        begin
            s_d.vhigh  = s_q.vlow; // RULE15
            s_d.dlatch = s_q.ctrl[`CCU_DLSB_MSB:`CCU_DLSB_LSB];
            s_d.out    = (duty_new != `CCU_DUTY_ZERO);
        end
        else if (duty_hit)
        begin
            s_d.out = 1'b0;
        end

        if (kind == CCU_K_OFF || zero_wr)
        begin
            s_d.out = 1'b0; // RULE8 RULE14
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o            = {24'h000000, s_q.rdat};
    assign wb_ack_o            = s_q.ack;
    assign unit_pin_o          = s_q.out;
    assign unit_pin_oe_o       = ~port_direction_i; // RULE13
    assign unit_irq_flag_o     = s_q.flag;
    // Trigger clear is a separate strobe, never an overflow
    assign timer_a_clear_o     = s_q.trig;
    assign timer_a_ovf_block_o = s_q.trig; // RULE12
    assign conv_start_o        = s_q.trig;
    // Timer B clears instead of incrementing on this strobe
    assign timer_b_clear_o     = per_hit; // RULE26

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence seq_trig_pulse;
        timer_a_clear_o && conv_start_o ##1 !timer_a_clear_o;
    endsequence

    sequence seq_pwm_reload;
        per_hit ##1 (s_q.vhigh == $past(s_q.vlow));
    endsequence

    sequence seq_pwm_set;
        per_hit ##1 unit_pin_o;
    endsequence

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_ack_answer: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not answered in one cycle");

    a_prescale_clear: assert property ((kind != CCU_K_CAP) |=> (s_q.ps == `CCU_PS_RST)) // RULE3
        else $error("prescaler not cleared outside capture");

    a_capture_copy: assert property (cap_ev |=> // RULE25
            ({s_q.vhigh, s_q.vlow} == $past(timer_a_count_i)) && unit_irq_flag_o)
        else $error("capture did not copy timer A");

    a_compare_set: assert property ((cmp_hit && mode == `CCU_M_CMP_SET && !zero_wr) |=> // RULE7
            unit_pin_o && unit_irq_flag_o)
        else $error("set-on-match failed");

    a_compare_clr: assert property ((cmp_hit && mode == `CCU_M_CMP_CLR) |=> // RULE7
            !unit_pin_o && unit_irq_flag_o)
        else $error("clear-on-match failed");

    a_swi_keep: assert property ((cmp_hit && mode == `CCU_M_CMP_SWI && !zero_wr) |=> // RULE10
            (unit_pin_o == $past(unit_pin_o)) && unit_irq_flag_o)
        else $error("software compare touched the pin");

    a_special_pulse: assert property ((cmp_hit && mode == `CCU_M_CMP_SPEC) |=> seq_trig_pulse) // RULE11
        else $error("special trigger not a single pulse");

    a_off_low: assert property ((kind == CCU_K_OFF) |=> !unit_pin_o) // RULE8
        else $error("output latch not low while off");

    a_pwm_reload: assert property (per_hit |-> seq_pwm_reload) // RULE15
        else $error("duty not reloaded at period match");

    a_duty_clear: assert property ((duty_hit && !per_hit && kind == CCU_K_PWM // RULE20
            && !zero_wr) |=> !unit_pin_o)
        else $error("pin not cleared at duty match");

    a_flag_sticky: assert property ((unit_irq_flag_o && !flag_clr) |=> unit_irq_flag_o) // RULE25
        else $error("flag dropped without software clear");

    a_match_once: assert property (cmp_hit |=> !cmp_hit) // RULE6
        else $error("compare acted twice on one match");

    a_compare_flag: assert property (cmp_hit |=> unit_irq_flag_o) // RULE24
        else $error("compare match did not set the flag");

    a_zero_write: assert property (zero_wr |=> !unit_pin_o) // RULE8 RULE14
        else $error("zero control write left the latch high");

    a_pwm_set: assert property ((per_hit && (duty_new != `CCU_DUTY_ZERO) && !zero_wr) // RULE15
            |-> seq_pwm_set)
        else $error("pin not set at period match");

    a_duty_latch: assert property (per_hit |=> // RULE19
            (s_q.dlatch == $past(s_q.ctrl[`CCU_DLSB_MSB:`CCU_DLSB_LSB])))
        else $error("duty low bits not latched at period match");

    a_vhigh_hold: assert property ((kind == CCU_K_PWM && !per_hit) |=> // RULE18
            (s_q.vhigh == $past(s_q.vhigh)))
        else $error("duty buffer changed inside a period");

endmodule : ccu_unit

// ==== ccu_pin_model.sv ====
/*
 * Pin-side party of the unit: an edge source while the unit listens,
 * a load on the driven pin otherwise.
 * Assumes the bench sets src_i and the port block gives oe_i.
 */
module ccu_pin_model
(
    input  wire logic drv_i,
    input  wire logic oe_i,
    input  wire logic src_i,
    output logic      pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Unit owns the wire while enabled; the source is then cut off
    assign pin_o = oe_i ? drv_i : src_i;
endmodule : ccu_pin_model

// ==== tb_top.sv ====
/*
 * Self-checking bench of ccu_unit: Wishbone tasks, timer models,
 * compare, capture and PWM sequences.
 * Assumes ccu_pkg and ccu_defines.svh are compiled first.
 */
`include "ccu_defines.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, rst_i, cyc, stb, we, ack, dir, src, pin, po, oe;
    logic        flag, ta_clr, ta_blk, conv, tb_clr, ta_stop, ta_zero, prev;
    logic [3:0]  adr;
    logic [31:0] wdat, rd, rdat;
    logic [15:0] ta, tamax;
    logic [7:0]  tbc, lo;
    logic [1:0]  ph;
    int          miscompares, total_checks, hi, rises;
    logic [3:0]  cm [5] = '{4'h8, 4'h9, 4'h8, 4'ha, 4'hb};
    logic        cp [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [3:0]  km [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
    int          kn [4] = '{1, 1, 4, 16};
    logic [9:0]  pd [3] = '{10'h006, 10'h000, 10'h014};
    int          ph_exp [3] = '{24, 0, 64};
    int          rs_exp [3] = '{4, 0, 0};

    ccu_unit u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .timer_a_count_i(ta), .timer_b_count_i(tbc), .timer_b_period_i(8'h03),
        .timer_b_inc_i(ph == 2'h3), .timer_b_phase_i(ph), .port_direction_i(dir),
        .unit_pin_i(pin), .unit_pin_o(po), .unit_pin_oe_o(oe), .unit_irq_flag_o(flag),
        .timer_a_clear_o(ta_clr), .timer_a_ovf_block_o(ta_blk), .conv_start_o(conv),
        .timer_b_clear_o(tb_clr));
    ccu_pin_model u_pin (.drv_i(po), .oe_i(oe), .src_i(src), .pin_o(pin));

    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk

    task automatic give_verdict;
        if (miscompares == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict

    // Entered just after an edge; holds the request until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20)
        begin
            chk(1'b0, "no ack");
            give_verdict();
        end
        @(posedge clk_i);
    endtask : wb

    task automatic wait_flag(input int lim);
        int n;
        n = 0;
        while (flag !== 1'b1 && n < lim)
        begin
            @(posedge clk_i);
            n++;
        end
    endtask : wait_flag

    task automatic pulse;
        src <= 1'b1;
        repeat (8) @(posedge clk_i);
        src <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask : pulse

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // Timers stay synchronous to clk_i
    always @(posedge clk_i)
    begin
        ph <= rst_i ? 2'h0 : ph + 2'h1;
        // Folded back past the period so PWM never waits for a full wrap
        tbc <= (rst_i || tb_clr || tbc > 8'h03) ? 8'h00 : tbc + {7'h00, ph == 2'h3};
        if (tb_clr === 1'b1 && (tbc !== 8'h03 || ph !== 2'h3))
            chk(1'b0, "timer B clear off period");
        if (rst_i || ta_clr || ta_zero)
            ta <= 16'h0000;
        else if (!ta_stop)
            ta <= ta + 16'h0001;
        if (ta > tamax)
            tamax <= ta;
        if (!rst_i && (ta_blk !== ta_clr || conv !== ta_clr))
            chk(1'b0, "trigger outputs differ");
    end

    initial
    begin
        rst_i = 1'b1;
        {cyc, stb, we, adr, wdat} = '0;
        {dir, src, ta_stop, ta_zero, tamax} = {3'b100, 1'b0, 16'h0000};
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            wb(1'b0, (i == 4) ? 4'h2 : 4'(i * 4), 8'h00);
            chk(rd === 32'h0 && po === 1'b0, "reset value");
        end
        dir <= 1'b0;
        wb(1'b1, `CCU_ADR_VLOW, 8'h40);
        wb(1'b1, `CCU_ADR_VHIGH, 8'h01);
        for (int i = 0; i < 5; i++)
        begin
            ta_zero <= 1'b1;
            wb(1'b1, `CCU_ADR_CTRL, {4'h0, cm[i]});
            wb(1'b1, `CCU_ADR_FLAG, 8'h01);
            chk(flag === 1'b0, "flag not cleared");
            ta_zero <= 1'b0;
            wait_flag(400);
            @(posedge clk_i);
            chk(flag === 1'b1 && po === cp[i], "compare action");
        end
        tamax = 16'h0000;
        repeat (700) @(posedge clk_i);
        chk(tamax === 16'h0141, "special event period");
        wb(1'b1, `CCU_ADR_CTRL, 8'h00);
        chk(po === 1'b0, "compare latch not cleared");
        dir <= 1'b1;
        ta_stop <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            wb(1'b1, `CCU_ADR_CTRL, 8'h00);
            wb(1'b1, `CCU_ADR_CTRL, {4'h0, km[i]});
            wb(1'b1, `CCU_ADR_FLAG, 8'h01);
            repeat (kn[i] - 1) pulse();
            chk(flag === 1'b0 && oe === 1'b0, "early capture");
            pulse();
            wb(1'b0, `CCU_ADR_VLOW, 8'h00);
            lo = rd[7:0];
            wb(1'b0, `CCU_ADR_VHIGH, 8'h00);
            chk({rd[7:0], lo} === ta && flag === 1'b1, "capture value");
        end
        wb(1'b1, `CCU_ADR_FLAG, 8'h01);
        repeat (3) pulse();
        wb(1'b1, `CCU_ADR_CTRL, {4'h0, `CCU_M_CAP_4TH});
        pulse();
        chk(flag === 1'b1, "prescale count lost on switch");
        wb(1'b1, `CCU_ADR_CTRL, 8'h00);
        dir <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            wb(1'b1, `CCU_ADR_VLOW, pd[i][9:2]);
            wb(1'b1, `CCU_ADR_CTRL, {2'h0, pd[i][1:0], 4'hc});
            repeat (40) @(posedge clk_i);
            wb(1'b1, `CCU_ADR_VHIGH, 8'hff);
            wb(1'b0, `CCU_ADR_VHIGH, 8'h00);
            chk(rd[7:0] === pd[i][9:2], "duty buffer");
            {hi, rises, prev} = {32'd0, 32'd0, po};
            repeat (64)
            begin
                @(posedge clk_i);
                hi += int'(po === 1'b1);
                rises += int'(po === 1'b1 && prev === 1'b0);
                prev = po;
            end
            chk(hi === ph_exp[i] && oe === 1'b1, "high time");
            chk(rises === rs_exp[i], "period count");
        end
        wb(1'b1, `CCU_ADR_CTRL, 8'h00);
        chk(po === 1'b0, "pwm latch not cleared");
        give_verdict();
    end

    initial
    begin
        #2000000;
        miscompares++;
        give_verdict();
    end
endmodule : tb_top
